/* hw/spccs_chan_sel.v */
// per-direction channel enable lookup, 32-channel or 128-channel scheme
`timescale 1ns/10ps
module spccs_chan_sel #(
	parameter NCH = 128
) (
	clk_sys,
	sys_rst,
	mc_enable,
	ext_enable,
	ena_words,
	channel,
	chan_enabled
);
	input  wire           clk_sys;      // system clock
	input  wire           sys_rst;      // synchronous reset
	input  wire           mc_enable;    // multichannel selection on
	input  wire           ext_enable;   // channel_extension_enable
	input  wire [NCH-1:0] ena_words;    // packed channel enables
	input  wire [6:0]     channel;      // channel now in the frame
	output reg            chan_enabled; // channel is serviced

	// ------------------------------------------------------------------
	// lookup
	// ------------------------------------------------------------------
	reg pick;
	// legacy scheme looks only at the first 32 enables; extension uses all
	always @* begin
		pick = 1'b1;
		if (mc_enable) begin
			if (ext_enable)
				pick = ena_words[channel];
			else
				pick = ena_words[{2'b00, channel[4:0]}];
		end
	end

	// registered so the frame logic sees a clean level
	always @(posedge clk_sys) begin
		if (sys_rst)
			chan_enabled <= 1'b0;
		else
			chan_enabled <= pick;
	end
endmodule

/* hw/spccs_defines.vh */
// register map, field positions, reset values and codes of the port control
`ifndef SPCCS_DEFINES_VH
`define SPCCS_DEFINES_VH

// ----------------------------------------------------------------------
// register indexes (16-bit words)
// ----------------------------------------------------------------------
`define SPCCS_IDX_PIN_CTL     5'h00
`define SPCCS_IDX_GEN_ONE     5'h01
`define SPCCS_IDX_GEN_TWO     5'h02
`define SPCCS_IDX_RX_CFG      5'h03
`define SPCCS_IDX_TX_CFG      5'h04
`define SPCCS_IDX_MC_ONE      5'h05
`define SPCCS_IDX_MC_TWO      5'h06
`define SPCCS_IDX_RX_ENA_HI   2'h1
`define SPCCS_IDX_TX_ENA_HI   2'h2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SPCCS_RST_WORD        16'h0000
`define SPCCS_RST_GEN_TWO     16'h2000

// ----------------------------------------------------------------------
// pin control fields
// ----------------------------------------------------------------------
`define SPCCS_PC_RX_GPIO      12
`define SPCCS_PC_TX_FDIR      11
`define SPCCS_PC_RX_FDIR      10
`define SPCCS_PC_TX_CDIR      9
`define SPCCS_PC_RX_CDIR      8
`define SPCCS_PC_EXT_SRC      7
`define SPCCS_PC_EXT_STAT     6
`define SPCCS_PC_TXD_STAT     5
`define SPCCS_PC_RXD_STAT     4
`define SPCCS_PC_TX_FPOL      3
`define SPCCS_PC_RX_FPOL      2
`define SPCCS_PC_TX_CPOL      1
`define SPCCS_PC_RX_CPOL      0

// ----------------------------------------------------------------------
// generator, direction config and multichannel fields
// ----------------------------------------------------------------------
`define SPCCS_G2_SRC          13
`define SPCCS_CFG_WLEN_HI     2
`define SPCCS_CFG_DUAL        3
`define SPCCS_CFG_FLEN_HI     10
`define SPCCS_CFG_FLEN_LO     4
`define SPCCS_CFG_STOP_HI     12
`define SPCCS_CFG_STOP_LO     11
`define SPCCS_MC_ENABLE       0
`define SPCCS_MC_EXT          9

// ----------------------------------------------------------------------
// generator input clock codes {extended bit, source bit}
// ----------------------------------------------------------------------
`define SPCCS_SRC_NONE        2'b00
`define SPCCS_SRC_CPU         2'b01
`define SPCCS_SRC_RXPIN       2'b10
`define SPCCS_SRC_TXPIN       2'b11

`endif

/* hw/spccs_top.v */
// serial port clock source, pin control and channel selection block
`timescale 1ns/10ps
`include "spccs_defines.vh"
module spccs_top (
	input  wire        clk_sys,            // 200 MHz system clock
	input  wire        sys_rst,            // synchronous, active high
	input  wire [4:0]  reg_addr,           // 16-bit word index
	input  wire        reg_wr,             // write strobe
	input  wire        reg_rd,             // read strobe
	input  wire [15:0] reg_wdata,          // write data
	output reg  [15:0] reg_rdata,          // read data, one cycle later
	input  wire        tx_clock_pin_in,    // transmit_clock_pin level
	input  wire        rx_clock_pin_in,    // receive_clock_pin level
	input  wire        ext_clock_pin_in,   // external_sample_clock_pin
	input  wire        rx_data_pin_in,     // receive data pin level
	output reg         tx_clock_pin_out,   // transmit clock drive value
	output reg         tx_clock_pin_oe,    // transmit clock driver on
	output reg         rx_clock_pin_out,   // receive clock drive value
	output reg         rx_clock_pin_oe,    // receive clock driver on
	output wire        tx_data_gpio_out,   // tx_data_pin_status value
	output wire        tx_frame_direction, // frame sync direction bits
	output wire        rx_frame_direction,
	output wire        tx_frame_polarity,  // frame sync polarity bits
	output wire        rx_frame_polarity,
	output reg         tx_shift_tick,      // one-cycle bit clock event
	output reg         rx_shift_tick,
	output reg  [5:0]  tx_word_bits,       // word length in bits
	output reg  [5:0]  rx_word_bits,
	output reg         clock_stop_mode,    // SPI-style operation active
	input  wire [6:0]  tx_channel,         // channel index from framer
	input  wire [6:0]  rx_channel,
	output wire        tx_chan_enabled,    // channel is serviced
	output wire        rx_chan_enabled
);

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	reg [15:0] pin_ctl_reg;   // serial_pin_control
	reg [15:0] gen_one_reg;   // generator divider in low byte
	reg [15:0] gen_two_reg;   // generator_config_two
	reg [15:0] rx_cfg_reg;    // rx word length, phase, stop mode
	reg [15:0] tx_cfg_reg;
	reg [15:0] mc_one_reg;    // multichannel_control_one (rx)
	reg [15:0] mc_two_reg;    // multichannel_control_two (tx)
	reg [15:0] ena_reg [0:15]; // 0..7 rx enables, 8..15 tx enables
	integer    i;

	// software writes; the upper reserved pin control bits stay zero
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_ctl_reg <= `SPCCS_RST_WORD;
			gen_one_reg <= `SPCCS_RST_WORD;
			gen_two_reg <= `SPCCS_RST_GEN_TWO;
			rx_cfg_reg  <= `SPCCS_RST_WORD;
			tx_cfg_reg  <= `SPCCS_RST_WORD;
			mc_one_reg  <= `SPCCS_RST_WORD;
			mc_two_reg  <= `SPCCS_RST_WORD;
			for (i = 0; i < 16; i = i + 1)
				ena_reg[i] <= `SPCCS_RST_WORD;
		end else if (reg_wr) begin
			case (reg_addr)
			`SPCCS_IDX_PIN_CTL: pin_ctl_reg <= {3'h0, reg_wdata[12:0]};
			`SPCCS_IDX_GEN_ONE: gen_one_reg <= reg_wdata;
			`SPCCS_IDX_GEN_TWO: gen_two_reg <= reg_wdata;
			`SPCCS_IDX_RX_CFG:  rx_cfg_reg  <= reg_wdata;
			`SPCCS_IDX_TX_CFG:  tx_cfg_reg  <= reg_wdata;
			`SPCCS_IDX_MC_ONE:  mc_one_reg  <= reg_wdata;
			`SPCCS_IDX_MC_TWO:  mc_two_reg  <= reg_wdata;
			default: begin
				// enable words: rx at 8..15, tx at 16..23
				if (reg_addr[4:3] == `SPCCS_IDX_RX_ENA_HI)
					ena_reg[{1'b0, reg_addr[2:0]}] <= reg_wdata;
				else if (reg_addr[4:3] == `SPCCS_IDX_TX_ENA_HI)
					ena_reg[{1'b1, reg_addr[2:0]}] <= reg_wdata;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// pin input synchronisers
	// ------------------------------------------------------------------
	reg [3:0] pin_s1_reg; // first stage, read only by the second
	reg [3:0] pin_s2_reg; // {rxd, ext, rxclk, txclk}
	reg [1:0] clk_d_reg;  // previous clock levels for edge finding
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_s1_reg <= 4'h0;
			pin_s2_reg <= 4'h0;
			clk_d_reg  <= 2'h0;
		end else begin
			pin_s1_reg <= {rx_data_pin_in, ext_clock_pin_in,
				rx_clock_pin_in, tx_clock_pin_in};
			pin_s2_reg <= pin_s1_reg;
			clk_d_reg  <= pin_s2_reg[1:0];
		end
	end
	wire tx_pin_rise = pin_s2_reg[0] & ~clk_d_reg[0];
	wire rx_pin_rise = pin_s2_reg[1] & ~clk_d_reg[1];
	wire tx_pin_fall = ~pin_s2_reg[0] & clk_d_reg[0];
	wire rx_pin_fall = ~pin_s2_reg[1] & clk_d_reg[1];

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	reg [15:0] rd_mux;
	// ext status shows its live pin, rx data status only with gpio enable; tx data status shows its setting
	always @* begin
		rd_mux = 16'h0000;
		case (reg_addr)
		`SPCCS_IDX_PIN_CTL: begin
			rd_mux = pin_ctl_reg;
			rd_mux[`SPCCS_PC_EXT_STAT] = pin_s2_reg[2];
			if (pin_ctl_reg[`SPCCS_PC_RX_GPIO])
				rd_mux[`SPCCS_PC_RXD_STAT] = pin_s2_reg[3];
		end
		`SPCCS_IDX_GEN_ONE: rd_mux = gen_one_reg;
		`SPCCS_IDX_GEN_TWO: rd_mux = gen_two_reg;
		`SPCCS_IDX_RX_CFG:  rd_mux = rx_cfg_reg;
		`SPCCS_IDX_TX_CFG:  rd_mux = tx_cfg_reg;
		`SPCCS_IDX_MC_ONE:  rd_mux = mc_one_reg;
		`SPCCS_IDX_MC_TWO:  rd_mux = mc_two_reg;
		default: begin
			if (reg_addr[4:3] == `SPCCS_IDX_RX_ENA_HI)
				rd_mux = ena_reg[{1'b0, reg_addr[2:0]}];
			else if (reg_addr[4:3] == `SPCCS_IDX_TX_ENA_HI)
				rd_mux = ena_reg[{1'b1, reg_addr[2:0]}];
		end
		endcase
	end

	// unmapped indexes read zero
	always @(posedge clk_sys) begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// ------------------------------------------------------------------
	// sample rate generator
	// ------------------------------------------------------------------
	wire [1:0] src_sel = {pin_ctl_reg[`SPCCS_PC_EXT_SRC],
		gen_two_reg[`SPCCS_G2_SRC]};
	reg        src_tick;
	// one tick per input clock event of the chosen source
	always @* begin
		case (src_sel)
		`SPCCS_SRC_CPU:   src_tick = 1'b1;
		`SPCCS_SRC_RXPIN: src_tick = rx_pin_rise;
		`SPCCS_SRC_TXPIN: src_tick = tx_pin_rise;
		default:          src_tick = 1'b0;
		endcase
	end

	reg [7:0] gen_cnt_reg; // ticks in the current half period
	reg       gen_clk_reg; // generator output level
	// half period is divider+1 source ticks
	always @(posedge clk_sys) begin
		if (sys_rst || src_sel == `SPCCS_SRC_NONE) begin
			gen_cnt_reg <= 8'h00;
			gen_clk_reg <= 1'b0;
		end else if (src_tick) begin
			if (gen_cnt_reg == gen_one_reg[7:0]) begin
				gen_cnt_reg <= 8'h00;
				gen_clk_reg <= ~gen_clk_reg;
			end else begin
				gen_cnt_reg <= gen_cnt_reg + 8'h01;
			end
		end
	end
	wire gen_rise = src_tick && gen_cnt_reg == gen_one_reg[7:0] &&
		!gen_clk_reg; // rising edge; src_tick is low for reserved code

	// ------------------------------------------------------------------
	// clock stop and word length
	// ------------------------------------------------------------------
	// stop mode is honoured only for one phase of one word
	wire tx_stop_ok = tx_cfg_reg[`SPCCS_CFG_STOP_HI:`SPCCS_CFG_STOP_LO] != 2'b00
		&& !tx_cfg_reg[`SPCCS_CFG_DUAL]
		&& tx_cfg_reg[`SPCCS_CFG_FLEN_HI:`SPCCS_CFG_FLEN_LO] == 7'h00;
	wire rx_stop_ok = !rx_cfg_reg[`SPCCS_CFG_DUAL]
		&& rx_cfg_reg[`SPCCS_CFG_FLEN_HI:`SPCCS_CFG_FLEN_LO] == 7'h00;

	function [5:0] wlen_bits;
		input [2:0] code;
		begin
			case (code)
			3'h0:    wlen_bits = 6'd8;
			3'h1:    wlen_bits = 6'd12;
			3'h2:    wlen_bits = 6'd16;
			3'h3:    wlen_bits = 6'd20;
			3'h4:    wlen_bits = 6'd24;
			default: wlen_bits = 6'd32;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// clock directions and pin drivers
	// ------------------------------------------------------------------
	wire tx_dir = pin_ctl_reg[`SPCCS_PC_TX_CDIR];
	// in stop mode the receiver follows the transmitter's role
	wire rx_dir = (tx_stop_ok && rx_stop_ok) ? tx_dir :
		pin_ctl_reg[`SPCCS_PC_RX_CDIR];
	wire tx_pin_is_src = src_sel == `SPCCS_SRC_TXPIN;
	wire rx_pin_is_src = src_sel == `SPCCS_SRC_RXPIN;
	wire tx_cpol = pin_ctl_reg[`SPCCS_PC_TX_CPOL];
	wire rx_cpol = pin_ctl_reg[`SPCCS_PC_RX_CPOL];

	// a pin feeding the generator never drives; the driven clock obeys
	// the polarity bit so the pin and the shift event stay aligned
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_clock_pin_out <= 1'b0;
			tx_clock_pin_oe  <= 1'b0;
			rx_clock_pin_out <= 1'b0;
			rx_clock_pin_oe  <= 1'b0;
			tx_shift_tick    <= 1'b0;
			rx_shift_tick    <= 1'b0;
			tx_word_bits     <= 6'd8;
			rx_word_bits     <= 6'd8;
			clock_stop_mode  <= 1'b0;
		end else begin
			tx_clock_pin_out <= gen_clk_reg ^ tx_cpol;
			tx_clock_pin_oe  <= tx_dir && !tx_pin_is_src;
			rx_clock_pin_out <= gen_clk_reg ^ rx_cpol;
			rx_clock_pin_oe  <= rx_dir && !rx_pin_is_src;
			// internal clocks come from the generator, else the pin
			tx_shift_tick <= tx_dir ? gen_rise :
				(tx_cpol ? tx_pin_fall : tx_pin_rise);
			rx_shift_tick <= rx_dir ? gen_rise :
				(rx_cpol ? rx_pin_fall : rx_pin_rise);
			tx_word_bits <= wlen_bits(tx_cfg_reg[`SPCCS_CFG_WLEN_HI:0]);
			rx_word_bits <= wlen_bits(rx_cfg_reg[`SPCCS_CFG_WLEN_HI:0]);
			clock_stop_mode <= tx_stop_ok && rx_stop_ok;
		end
	end

	// ------------------------------------------------------------------
	// loose control bits
	// ------------------------------------------------------------------
	assign tx_data_gpio_out   = pin_ctl_reg[`SPCCS_PC_TXD_STAT];
	assign tx_frame_direction = pin_ctl_reg[`SPCCS_PC_TX_FDIR];
	assign rx_frame_direction = pin_ctl_reg[`SPCCS_PC_RX_FDIR];
	assign tx_frame_polarity  = pin_ctl_reg[`SPCCS_PC_TX_FPOL];
	assign rx_frame_polarity  = pin_ctl_reg[`SPCCS_PC_RX_FPOL];

	// ------------------------------------------------------------------
	// channel selection per direction
	// ------------------------------------------------------------------
	wire [127:0] rx_ena_flat;
	wire [127:0] tx_ena_flat;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_pack
			assign rx_ena_flat[g*16 +: 16] = ena_reg[g];
			assign tx_ena_flat[g*16 +: 16] = ena_reg[g+8];
		end
	endgenerate

	spccs_chan_sel #(.NCH(128)) u_rx_sel (
		.clk_sys      (clk_sys),
		.sys_rst      (sys_rst),
		.mc_enable    (mc_one_reg[`SPCCS_MC_ENABLE]),
		.ext_enable   (mc_one_reg[`SPCCS_MC_EXT]),
		.ena_words    (rx_ena_flat),
		.channel      (rx_channel),
		.chan_enabled (rx_chan_enabled)
	);

	spccs_chan_sel #(.NCH(128)) u_tx_sel (
		.clk_sys      (clk_sys),
		.sys_rst      (sys_rst),
		.mc_enable    (mc_two_reg[`SPCCS_MC_ENABLE]),
		.ext_enable   (mc_two_reg[`SPCCS_MC_EXT]),
		.ena_words    (tx_ena_flat),
		.channel      (tx_channel),
		.chan_enabled (tx_chan_enabled)
	);
endmodule

/* sim/spccs_chk.sv */
// assertion checker watching the port control block at its ports
`timescale 1ns/10ps
`include "spccs_defines.vh"
module spccs_chk (
	input wire        clk_sys,
	input wire        sys_rst,
	input wire [4:0]  reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire        tx_clock_pin_oe,
	input wire        rx_clock_pin_oe,
	input wire        tx_shift_tick,
	input wire        rx_shift_tick,
	input wire [5:0]  tx_word_bits,
	input wire        tx_frame_direction,
	input wire        rx_frame_polarity,
	input wire        tx_data_gpio_out,
	input wire        rx_chan_enabled
);
	// ------
	// shadow of written control words
	// ------
	reg  [15:0] pin_reg;   // pin control as written
	reg         src_reg;   // generator source bit as written
	reg         mc_reg;    // receive selection on
	reg  [2:0]  quiet_reg; // cycles since last write, saturating
	wire [1:0]  src;       // generator input code
	wire        settled;   // outputs caught up with the last write
	assign src = {pin_reg[`SPCCS_PC_EXT_SRC], src_reg};
	assign settled = (quiet_reg > 3'h3);
	// mirror writes; reset values match the block's own
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_reg <= 16'h0000;
			src_reg <= 1'b1;
			mc_reg <= 1'b0;
			quiet_reg <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == `SPCCS_IDX_PIN_CTL)
				pin_reg <= reg_wdata;
			if (reg_wr && reg_addr == `SPCCS_IDX_GEN_TWO)
				src_reg <= reg_wdata[`SPCCS_G2_SRC];
			if (reg_wr && reg_addr == `SPCCS_IDX_MC_ONE)
				mc_reg <= reg_wdata[`SPCCS_MC_ENABLE];
			// any write restarts the settling count
			if (reg_wr)
				quiet_reg <= 3'h0;
			else if (quiet_reg != 3'h7)
				quiet_reg <= quiet_reg + 3'h1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// ------
	// assertions
	// ------
	a_pin_rsvd: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata[15:13] == 3'b000)
		else $error("reserved pin bits read nonzero");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_frame_dir: assert property (settled |-> tx_frame_direction == pin_reg[11])
		else $error("frame direction differs from register");
	a_pol_stat: assert property (settled |-> rx_frame_polarity == pin_reg[2] && tx_data_gpio_out == pin_reg[5])
		else $error("polarity or status differs");
	a_tx_noout: assert property (settled && src == 2'b11 |-> !tx_clock_pin_oe)
		else $error("tx pin driven while it feeds generator");
	a_rx_noout: assert property (settled && src == 2'b10 |-> !rx_clock_pin_oe)
		else $error("rx pin driven while it feeds generator");
	a_tx_oe_dir: assert property (settled && src == 2'b01 |-> tx_clock_pin_oe == pin_reg[9])
		else $error("tx driver does not follow direction");
	a_none_quiet: assert property (settled && src == 2'b00 && pin_reg[9] |-> !tx_shift_tick)
		else $error("tick with reserved source");
	a_tick_once: assert property (tx_shift_tick |=> !tx_shift_tick)
		else $error("tick longer than one cycle");
	a_word_legal: assert property (tx_word_bits inside {6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h20})
		else $error("illegal word length");
	a_chan_all: assert property (settled && !mc_reg |-> rx_chan_enabled)
		else $error("channel off with selection off");
	c_rx_src: cover property (src == 2'b10 && tx_shift_tick);
	c_both_ticks: cover property (tx_shift_tick && rx_shift_tick);
	c_chan_off: cover property (mc_reg && !rx_chan_enabled);
endmodule

/* sim/spccs_peer.sv */
// serial peer: clocks the link lines and drives the data pins
`timescale 1ns/10ps
module spccs_peer #(
	parameter HALF_NS = 32
) (
	input  wire run,
	input  wire data_lvl,
	input  wire ext_lvl,
	output reg  clk_line,
	output wire data_line,
	output wire ext_line
);
	// data and external clock pin follow the requested levels
	assign data_line = data_lvl;
	assign ext_line = ext_lvl;
	// link clock runs only within bursts and stands low between them
	initial clk_line = 1'b0;
	always begin
		if (run === 1'b1) begin
			#(HALF_NS) clk_line = ~clk_line;
		end else begin
			clk_line = 1'b0;
			@(posedge run);
		end
	end
endmodule

/* sim/spccs_top_tb_top.sv */
// bench top: register tests, link clock bursts, channel lookups
`timescale 1ns/10ps
`include "spccs_defines.vh"
module spccs_top_tb_top;
	reg         clk_sys = 1'b0;       // 200 MHz system clock
	reg         sys_rst = 1'b1;       // held 8 cycles at start
	reg  [4:0]  reg_addr = 5'h00;     // word index
	reg         reg_wr = 1'b0;        // write strobe
	reg         reg_rd = 1'b0;        // read strobe
	reg  [15:0] reg_wdata = 16'h0000; // write data
	reg         peer_run = 1'b0;      // peer clocks its lines
	reg         data_lvl = 1'b0;      // peer receive data level
	reg         ext_lvl = 1'b0;       // peer external clock level
	reg  [6:0]  tx_channel = 7'h00;   // framer channel indexes
	reg  [6:0]  rx_channel = 7'h00;
	wire [15:0] reg_rdata;
	wire        peer_clk, rx_data_pin_in, ext_clock_pin_in;
	wire        tx_clock_pin_out, tx_clock_pin_oe;
	wire        rx_clock_pin_out, rx_clock_pin_oe;
	wire        tx_shift_tick, rx_shift_tick, clock_stop_mode;
	wire [5:0]  tx_word_bits, rx_word_bits;
	wire        tx_chan_enabled, rx_chan_enabled, tx_data_gpio_out;
	wire        tx_clock_pin_in, rx_clock_pin_in; // resolved pins
	wire        rx_frame_direction, tx_frame_polarity; // loose bits
	integer     mismatches = 0;
	integer     cmp_count = 0;
	integer     i, nt, nr;            // loop index, tick counts
	// a pin shows the block's drive while enabled, else the peer
	assign tx_clock_pin_in = tx_clock_pin_oe ? tx_clock_pin_out : peer_clk;
	assign rx_clock_pin_in = rx_clock_pin_oe ? rx_clock_pin_out : peer_clk;
	always #2.5 clk_sys = ~clk_sys;
	spccs_peer i_spccs_peer (.run(peer_run), .data_lvl, .ext_lvl,
		.clk_line(peer_clk), .data_line(rx_data_pin_in),
		.ext_line(ext_clock_pin_in));
	spccs_top i_spccs_top (.clk_sys, .sys_rst, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .tx_clock_pin_in,
		.rx_clock_pin_in, .ext_clock_pin_in, .rx_data_pin_in,
		.tx_clock_pin_out, .tx_clock_pin_oe, .rx_clock_pin_out,
		.rx_clock_pin_oe, .tx_data_gpio_out, .tx_frame_direction(),
		.rx_frame_direction, .tx_frame_polarity,
		.rx_frame_polarity(), .tx_shift_tick, .rx_shift_tick,
		.tx_word_bits, .rx_word_bits, .clock_stop_mode, .tx_channel,
		.rx_channel, .tx_chan_enabled, .rx_chan_enabled);
	// ------
	// shared tasks
	// ------
	task chk(input string nm, input [15:0] seen, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("wrong value %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// one-cycle strobe; next call waits an edge, so no double drive
	task wr(input [4:0] a, input [15:0] d);
		begin
			@(negedge clk_sys);
			reg_addr = a;
			reg_wdata = d;
			reg_wr = 1'b1;
			@(negedge clk_sys);
			reg_wr = 1'b0;
		end
	endtask
	// read data holds until the next read, so a late look is safe
	task rd(input [4:0] a, input [15:0] exp, input string nm);
		begin
			@(negedge clk_sys);
			reg_addr = a;
			reg_rd = 1'b1;
			@(negedge clk_sys);
			reg_rd = 1'b0;
			@(negedge clk_sys);
			chk(nm, reg_rdata, exp);
		end
	endtask
	task wait_n(input integer n);
		repeat (n) @(negedge clk_sys);
	endtask
	// ticks are one cycle wide, so sampling each falling edge counts all
	task count(input integer n);
		begin
			nt = 0;
			nr = 0;
			repeat (n) begin
				@(negedge clk_sys);
				nt = nt + (tx_shift_tick === 1'b1);
				nr = nr + (rx_shift_tick === 1'b1);
			end
		end
	endtask
	// receive clock direction is 0, so its driver shows stop mode
	task stopc(input [15:0] tx, input [15:0] rx, input exp);
		begin
			wr(`SPCCS_IDX_TX_CFG, tx);
			wr(`SPCCS_IDX_RX_CFG, rx);
			wait_n(3);
			chk("stop_mode", clock_stop_mode, exp);
			chk("rx_oe", rx_clock_pin_oe, exp);
		end
	endtask
	function [15:0] wlen(input integer k);
		wlen = (k < 5) ? 16'h0008 + 16'h0004 * k[15:0] : 16'h0020;
	endfunction
	task end_of_test;
		begin
			$display("compares %0d mismatches %0d", cmp_count, mismatches);
			if (mismatches == 0 && cmp_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// ------
	// test sequence
	// ------
	initial begin
		repeat (8) @(negedge clk_sys);
		sys_rst = 1'b0;
		rd(`SPCCS_IDX_PIN_CTL, 16'h0000, "pin_rst");
		rd(`SPCCS_IDX_GEN_TWO, 16'h2000, "gen_rst");
		rd(`SPCCS_IDX_MC_ONE, 16'h0000, "mc_rst");
		wr(5'h07, 16'hFFFF);
		rd(5'h07, 16'h0000, "unmapped");
		// status bits follow the live pins while gpio enable is set
		data_lvl = 1'b1;
		wr(`SPCCS_IDX_PIN_CTL, 16'hFFFF);
		rd(`SPCCS_IDX_PIN_CTL, 16'h1FBF, "pin_live");
		data_lvl = 1'b0;
		ext_lvl = 1'b1;
		wait_n(4);
		rd(`SPCCS_IDX_PIN_CTL, 16'h1FEF, "pin_live");
		wr(`SPCCS_IDX_PIN_CTL, 16'h0F3F);
		rd(`SPCCS_IDX_PIN_CTL, 16'h0F7F, "pin_kept");
		chk("gpio_out", tx_data_gpio_out, 1'b1);
		chk("frame_bits", {rx_frame_direction, tx_frame_polarity}, 2'b11);
		// every word code; the spare codes give the widest word
		for (i = 0; i < 8; i = i + 1) begin
			wr(`SPCCS_IDX_TX_CFG, i[15:0]);
			wr(`SPCCS_IDX_RX_CFG, i[15:0]);
			wait_n(2);
			chk("tx_bits", tx_word_bits, wlen(i));
			chk("rx_bits", rx_word_bits, wlen(i));
		end
		wr(`SPCCS_IDX_PIN_CTL, 16'h0200);
		chk("frame_bits", {rx_frame_direction, tx_frame_polarity}, 2'b00);
		stopc(16'h0800, 16'h0000, 1'b1);
		stopc(16'h0808, 16'h0000, 1'b0);
		stopc(16'h0810, 16'h0000, 1'b0);
		stopc(16'h0800, 16'h0008, 1'b0);
		stopc(16'h0000, 16'h0000, 1'b0);
		// cpu source, divider 0: one tick every two cycles
		wr(`SPCCS_IDX_PIN_CTL, 16'h0300);
		wr(`SPCCS_IDX_GEN_ONE, 16'h0000);
		wait_n(4);
		count(40);
		chk("cpu_ticks", nt > 18 && nt < 22 && nr > 18 && nr < 22, 1'b1);
		wr(`SPCCS_IDX_GEN_TWO, 16'h0000);
		wait_n(4);
		count(40);
		chk("no_ticks", nt + nr == 0, 1'b1);
		chk("oe_kept", {tx_clock_pin_oe, rx_clock_pin_oe}, 2'b11);
		// generator held low, so the driven pins show only polarity
		wr(`SPCCS_IDX_PIN_CTL, 16'h0302);
		wait_n(2);
		chk("clk_pol", {tx_clock_pin_out, rx_clock_pin_out}, 2'b10);
		// peer bursts; generator ticks every two pin periods
		wr(`SPCCS_IDX_PIN_CTL, 16'h0380);
		peer_run = 1'b1;
		wait_n(8);
		count(205);
		chk("rxpin_ticks", nt > 6 && nt < 10, 1'b1);
		chk("pin_oe", {tx_clock_pin_oe, rx_clock_pin_oe}, 2'b10);
		wr(`SPCCS_IDX_GEN_TWO, 16'h2000);
		wait_n(8);
		count(205);
		chk("txpin_ticks", nt > 6 && nt < 10, 1'b1);
		chk("pin_oe", {tx_clock_pin_oe, rx_clock_pin_oe}, 2'b01);
		peer_run = 1'b0;
		// channel 37: legacy uses word 0 bit 5, extended word 2 bit 5
		wr(`SPCCS_IDX_MC_ONE, 16'h0001);
		wr(5'h08, 16'h0020);
		wr(5'h0A, 16'h0000);
		rx_channel = 7'h25;
		tx_channel = 7'h25;
		wait_n(2);
		chk("rx_legacy", rx_chan_enabled, 1'b1);
		rx_channel = 7'h26;
		wait_n(2);
		chk("rx_legacy", rx_chan_enabled, 1'b0);
		rx_channel = 7'h25;
		wr(`SPCCS_IDX_MC_ONE, 16'h0201);
		wait_n(2);
		chk("rx_ext", rx_chan_enabled, 1'b0);
		wr(5'h0A, 16'h0020);
		wait_n(2);
		chk("rx_ext", rx_chan_enabled, 1'b1);
		chk("tx_all", tx_chan_enabled, 1'b1);
		wr(`SPCCS_IDX_MC_TWO, 16'h0001);
		wait_n(2);
		chk("tx_sel", {tx_chan_enabled, rx_chan_enabled}, 2'b01);
		// second reset in mid-run
		sys_rst = 1'b1;
		wait_n(2);
		sys_rst = 1'b0;
		// register read first; the pin status needs two synchroniser edges
		rd(`SPCCS_IDX_MC_ONE, 16'h0000, "mc_rst2");
		rd(`SPCCS_IDX_PIN_CTL, 16'h0040, "pin_rst2");
		end_of_test;
	end
	// watchdog well beyond the expected run length
	initial begin
		#100000;
		mismatches = mismatches + 1;
		end_of_test;
	end
endmodule
bind spccs_top spccs_chk i_spccs_chk (.clk_sys, .sys_rst, .reg_addr,
	.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_clock_pin_oe,
	.rx_clock_pin_oe, .tx_shift_tick, .rx_shift_tick, .tx_word_bits,
	.tx_frame_direction, .rx_frame_polarity, .tx_data_gpio_out,
	.rx_chan_enabled);
